// [core/prds_pkg.sv]
/*
 * Shared constants for the program recall and approach-stroke block.
 * Assumes a 50 MHz system clock; all inputs arrive synchronous to it.
 */
package prds_pkg;

	// =====================================================================
	// Clock and timing
	// =====================================================================
	localparam int  CLK_HZ            = 50000000;
	// Fixed pre-cycle delay on the first weld, in seconds.
	localparam real APPROACH_DELAY_S  = 0.6;
	localparam int  APPROACH_DELAY_CY = int'(APPROACH_DELAY_S * CLK_HZ);
	localparam int  DELAY_CNT_W       = 25;

	// =====================================================================
	// Program number
	// =====================================================================
	localparam int         PROG_W        = 7;
	localparam logic [6:0] PROG_NONE     = 7'h00;
	localparam logic [6:0] PROG_RESET    = 7'h01;
	localparam logic [6:0] PROG_MAX      = 7'h7F;

	// =====================================================================
	// Sequencer states, Gray coded along idle, delay, weld
	// =====================================================================
	typedef enum logic [1:0] {
		PRDS_IDLE  = 2'h0,
		PRDS_DELAY = 2'h1,
		PRDS_WELD  = 2'h3
	} prds_state_type;

endpackage : prds_pkg

// [core/prds_delay_timer.sv]
/*
 * One-shot down counter producing a single-cycle done pulse.
 * Assumes start is a single-cycle pulse and a clock enable freezes it.
 */
`timescale 1ns/10ps

module prds_delay_timer #(
	parameter int DELAY_CYCLES = prds_pkg::APPROACH_DELAY_CY
) (
	// Clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_clk_en,
	// Control
	input  wire logic i_start,
	// Status
	output logic      o_busy,
	output logic      o_done
);

	// =====================================================================
	// Counter
	// =====================================================================
	localparam logic [prds_pkg::DELAY_CNT_W-1:0] LOAD_VAL =
		prds_pkg::DELAY_CNT_W'(DELAY_CYCLES - 1);

	logic [prds_pkg::DELAY_CNT_W-1:0] cnt_r;
	logic [prds_pkg::DELAY_CNT_W-1:0] cnt_nxt;
	logic                             busy_r;
	logic                             busy_nxt;
	logic                             done_r;
	logic                             done_nxt;

	always_comb begin
		cnt_nxt  = cnt_r;
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		if (i_start) begin
			cnt_nxt  = LOAD_VAL;
			busy_nxt = 1'b1;
		end else if (busy_r) begin
			if (cnt_r == '0) begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r - 1'b1;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			cnt_r  <= '0;
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else if (i_clk_en) begin
			cnt_r  <= cnt_nxt;
			busy_r <= busy_nxt;
			done_r <= done_nxt;
		end
	end

	assign o_busy = busy_r;
	assign o_done = done_r;

endmodule : prds_delay_timer

// [core/prds_ctrl.sv]
/*
 * Top of the program recall and approach-stroke block: decodes the seven
 * recall lines into a program number taken at cycle start, and runs the
 * approach-stroke valve with its fixed first-weld delay.
 * Assumes an external weld sequencer that starts on o_weld_go and reports
 * the end of each weld with a one-cycle i_cycle_end pulse.
 */
`timescale 1ns/10ps

module prds_ctrl #(
	parameter int APPROACH_DELAY_CY = prds_pkg::APPROACH_DELAY_CY
) (
	// Clock, reset and enable
	input  wire logic                        i_sys_clk,
	input  wire logic                        i_sys_rst,
	input  wire logic                        i_clk_en,
	// Recall lines from the machine controller
	input  wire logic                        i_recall_in_weight1,
	input  wire logic                        i_recall_in_weight2,
	input  wire logic                        i_recall_in_weight4,
	input  wire logic                        i_recall_in_weight8,
	input  wire logic                        i_recall_in_weight16,
	input  wire logic                        i_recall_in_weight32,
	input  wire logic                        i_recall_in_weight64,
	// Approach-stroke request and cycle control
	input  wire logic                        i_approach_req,
	input  wire logic                        i_cycle_start,
	input  wire logic                        i_cycle_end,
	// Program selection
	output logic [prds_pkg::PROG_W-1:0]      o_prog_num,
	// Valve and sequencer handshake
	output logic                             o_approach_valve_out,
	output logic                             o_weld_go,
	output logic                             o_delay_busy,
	output logic                             o_cycle_busy
);

	// =====================================================================
	// Recall decode
	// =====================================================================
	logic [prds_pkg::PROG_W-1:0] recall_code;

	// Each line lands on the bit of its weight, so the code is the number.
	assign recall_code = {i_recall_in_weight64, i_recall_in_weight32,
	                      i_recall_in_weight16, i_recall_in_weight8,
	                      i_recall_in_weight4,  i_recall_in_weight2,
	                      i_recall_in_weight1};

	// =====================================================================
	// Cycle-start edge detect
	// =====================================================================
	logic                     start_d_r;
	logic                     start_d_nxt;
	logic                     start_edge;
	prds_pkg::prds_state_type state_r;
	prds_pkg::prds_state_type state_nxt;

	assign start_edge  = i_cycle_start & ~start_d_r;

	always_comb begin
		start_d_nxt = i_cycle_start;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			start_d_r <= 1'b0;
		end else if (i_clk_en) begin
			start_d_r <= start_d_nxt;
		end
	end

	// =====================================================================
	// Program number register
	// =====================================================================
	logic [prds_pkg::PROG_W-1:0] prog_r;
	logic [prds_pkg::PROG_W-1:0] prog_nxt;

	always_comb begin
		prog_nxt = prog_r;
		// Lines are sampled in the same cycle as the start edge.
		// A start refused mid-cycle must not swap the program of a running weld.
		if (start_edge && (state_r == prds_pkg::PRDS_IDLE) &&
		    (recall_code != prds_pkg::PROG_NONE)) begin
			prog_nxt = recall_code;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			prog_r <= prds_pkg::PROG_RESET;
		end else if (i_clk_en) begin
			prog_r <= prog_nxt;
		end
	end

	// =====================================================================
	// Approach delay timer
	// =====================================================================
	logic timer_start;
	logic timer_busy;
	logic timer_done;

	prds_delay_timer #(
		.DELAY_CYCLES (APPROACH_DELAY_CY)
	) u_delay_timer (
		.i_sys_clk (i_sys_clk),
		.i_sys_rst (i_sys_rst),
		.i_clk_en  (i_clk_en),
		.i_start   (timer_start),
		.o_busy    (timer_busy),
		.o_done    (timer_done)
	);

	// =====================================================================
	// Cycle and valve sequencer
	// =====================================================================
	logic                     valve_r;
	logic                     valve_nxt;
	logic                     go_r;
	logic                     go_nxt;
	logic                     delay_busy_r;
	logic                     delay_busy_nxt;
	logic                     cycle_busy_r;
	logic                     cycle_busy_nxt;

	// No key selector input exists: the valve never depends on it.
	always_comb begin
		state_nxt   = state_r;
		valve_nxt   = valve_r;
		go_nxt      = 1'b0;
		timer_start = 1'b0;
		unique case (state_r)
			prds_pkg::PRDS_IDLE: begin
				// Outside a cycle the valve drops as soon as the request goes.
				if (!i_approach_req) begin
					valve_nxt = 1'b0;
				end
				if (start_edge) begin
					if (i_approach_req && !valve_r) begin
						// Valve off at reset is only raised here, on a start.
						valve_nxt   = 1'b1;
						timer_start = 1'b1;
						state_nxt   = prds_pkg::PRDS_DELAY;
					end else begin
						go_nxt    = 1'b1;
						state_nxt = prds_pkg::PRDS_WELD;
					end
				end
			end
			prds_pkg::PRDS_DELAY: begin
				if (timer_done) begin
					go_nxt    = 1'b1;
					state_nxt = prds_pkg::PRDS_WELD;
				end
			end
			prds_pkg::PRDS_WELD: begin
				// Valve holds through the weld; request changes wait for the end.
				if (i_cycle_end) begin
					state_nxt = prds_pkg::PRDS_IDLE;
					// A request raised mid-cycle is not acted on here.
					valve_nxt = valve_r & i_approach_req;
				end
			end
			default: begin
				state_nxt = prds_pkg::PRDS_IDLE;
			end
		endcase
		delay_busy_nxt = (state_nxt == prds_pkg::PRDS_DELAY);
		cycle_busy_nxt = (state_nxt != prds_pkg::PRDS_IDLE);
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			state_r      <= prds_pkg::PRDS_IDLE;
			valve_r      <= 1'b0;
			go_r         <= 1'b0;
			delay_busy_r <= 1'b0;
			cycle_busy_r <= 1'b0;
		end else if (i_clk_en) begin
			state_r      <= state_nxt;
			valve_r      <= valve_nxt;
			go_r         <= go_nxt;
			delay_busy_r <= delay_busy_nxt;
			cycle_busy_r <= cycle_busy_nxt;
		end
	end

	// =====================================================================
	// Outputs
	// =====================================================================
	assign o_prog_num           = prog_r;
	assign o_approach_valve_out = valve_r;
	assign o_weld_go            = go_r;
	assign o_delay_busy         = delay_busy_r;
	assign o_cycle_busy         = cycle_busy_r;

endmodule : prds_ctrl

// [verif/prds_ctrl_asserts.sv]
/* Port checker for prds_ctrl.
   Assumes it is bound to prds_ctrl with the same delay parameter. */
`timescale 1ns/10ps
module prds_ctrl_asserts #(
	parameter int APPROACH_DELAY_CY = 8
) (
	// Clock and control
	input wire logic       i_sys_clk,
	input wire logic       i_sys_rst,
	input wire logic       i_clk_en,
	input wire logic       i_approach_req,
	input wire logic       i_cycle_start,
	input wire logic       i_cycle_end,
	// Recall lines
	input wire logic       i_recall_in_weight1,
	input wire logic       i_recall_in_weight2,
	input wire logic       i_recall_in_weight4,
	input wire logic       i_recall_in_weight8,
	input wire logic       i_recall_in_weight16,
	input wire logic       i_recall_in_weight32,
	input wire logic       i_recall_in_weight64,
	// Outputs
	input wire logic [6:0] o_prog_num,
	input wire logic       o_approach_valve_out,
	input wire logic       o_weld_go,
	input wire logic       o_delay_busy,
	input wire logic       o_cycle_busy
);
	// ==========================================================
	// Properties
	localparam int DLO = APPROACH_DELAY_CY;
	localparam int DHI = APPROACH_DELAY_CY + 1;
	wire [6:0] code = {i_recall_in_weight64, i_recall_in_weight32, i_recall_in_weight16,
		i_recall_in_weight8, i_recall_in_weight4, i_recall_in_weight2, i_recall_in_weight1};
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst || !i_clk_en);
	sequence s_start; $rose(o_cycle_busy); endsequence
	sequence s_go; o_weld_go && !o_delay_busy; endsequence
	property p_prog_hold; !$rose(o_cycle_busy) |-> $stable(o_prog_num); endproperty
	a_prog_hold: assert property (p_prog_hold) else $error("program moved");
	property p_prog_code;
		s_start |-> o_prog_num == (($past(code) != 7'h00) ? $past(code) : $past(o_prog_num));
	endproperty
	a_prog_code: assert property (p_prog_code) else $error("bad program");
	property p_valve_rise;
		$rose(o_approach_valve_out) |-> $rose(o_delay_busy) && $past(i_approach_req);
	endproperty
	a_valve_rise: assert property (p_valve_rise) else $error("valve rose");
	property p_delay; s_start ##0 o_delay_busy |-> !o_weld_go ##[DLO:DHI] s_go; endproperty
	a_delay: assert property (p_delay) else $error("delay length");
	property p_quick; $rose(o_cycle_busy) && $past(o_approach_valve_out) |-> s_go; endproperty
	a_quick: assert property (p_quick) else $error("late weld");
	property p_end;
		$fell(o_cycle_busy) |->
			o_approach_valve_out == ($past(o_approach_valve_out) && $past(i_approach_req));
	endproperty
	a_end: assert property (p_end) else $error("valve at end");
	property p_hold; o_cycle_busy && $past(o_cycle_busy) |-> $stable(o_approach_valve_out);
	endproperty
	a_hold: assert property (p_hold) else $error("valve moved");
	property p_idle_off;
		!$past(o_cycle_busy) && !$past(i_approach_req) |-> !o_approach_valve_out;
	endproperty
	a_idle_off: assert property (p_idle_off) else $error("valve on idle");
	property p_pulse; o_weld_go |=> !o_weld_go; endproperty
	a_pulse: assert property (p_pulse) else $error("long go");
endmodule : prds_ctrl_asserts

// [verif/prds_seq_model.sv]
/* Weld sequencer model: ends each weld i_len cycles after weld go.
   Assumes the prds_ctrl clock and reset. */
`timescale 1ns/10ps
module prds_seq_model (
	// Clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_sys_rst,
	// Handshake
	input  wire logic       i_weld_go,
	input  wire logic [7:0] i_len,
	output logic            o_cycle_end
);
	// ==========================================================
	// Weld length counter
	logic [7:0] cnt;
	initial o_cycle_end = 1'b0;
	always @(posedge i_sys_clk) begin
		#1;
		o_cycle_end = 1'b0;
		if (i_sys_rst) begin
			cnt = 8'h00;
		end else if (i_weld_go) begin
			cnt = i_len;
		end else if (cnt != 8'h00) begin
			cnt = cnt - 8'h01;
			o_cycle_end = (cnt == 8'h00);
		end
	end
endmodule : prds_seq_model

// [verif/prds_ctrl_tb.sv]
/* Self-checking bench for prds_ctrl with a sequencer model.
   Assumes a shortened approach delay of N cycles. */
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin bad_count++; \
	$display("[ERR] %0t mismatch", $time); end end
module prds_ctrl_tb;
	// ==========================================================
	// Signals and instances
	localparam int N = 8;
	localparam logic [6:0] CODES [6] = '{7'h01, 7'h2A, 7'h55, 7'h40, 7'h7F, 7'h00};
	logic       i_sys_clk = 1'b0;
	logic       i_sys_rst = 1'b1;
	logic       clk_en = 1'b1;
	logic       i_approach_req = 1'b0;
	logic       i_cycle_start = 1'b0;
	logic [6:0] code = 7'h00;
	logic [7:0] len = 8'h01;
	logic       i_cycle_end;
	logic [6:0] o_prog_num;
	logic       o_approach_valve_out, o_weld_go, o_delay_busy, o_cycle_busy, vmid;
	int         bad_count = 0, tests_run = 0, n = 0, cyc = 0;
	prds_ctrl #(.APPROACH_DELAY_CY(N)) dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
		.i_clk_en(clk_en), .i_recall_in_weight1(code[0]),
		.i_recall_in_weight2(code[1]), .i_recall_in_weight4(code[2]),
		.i_recall_in_weight8(code[3]), .i_recall_in_weight16(code[4]),
		.i_recall_in_weight32(code[5]), .i_recall_in_weight64(code[6]),
		.i_approach_req(i_approach_req), .i_cycle_start(i_cycle_start),
		.i_cycle_end(i_cycle_end), .o_prog_num(o_prog_num),
		.o_approach_valve_out(o_approach_valve_out), .o_weld_go(o_weld_go),
		.o_delay_busy(o_delay_busy), .o_cycle_busy(o_cycle_busy));
	prds_seq_model model (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
		.i_weld_go(o_weld_go), .i_len(len), .o_cycle_end(i_cycle_end));
	initial forever #10 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 6000) begin
			bad_count++;
			final_report();
		end
	end
	task automatic step(input int k);
		repeat (k) @(posedge i_sys_clk);
		#1;
	endtask : step
	task automatic do_reset();
		i_sys_rst = 1'b1;
		step(4);
		i_sys_rst = 1'b0;
	endtask : do_reset
	// Recall code goes up together with start; mreq is applied mid-weld.
	task automatic go(input logic [6:0] c, input logic mreq);
		code = c;
		i_cycle_start = 1'b1;
		n = 0;
		while (o_weld_go !== 1'b1 && n < 100) begin
			step(1);
			n++;
		end
		i_approach_req = mreq;
		step(2);
		vmid = o_approach_valve_out;
		while (o_cycle_busy !== 1'b0) step(1);
		i_cycle_start = 1'b0;
		step(1);
	endtask : go
	task automatic t_recall();
		logic [6:0] exp;
		exp = 7'h01;
		`CHK(o_prog_num, 7'h01)
		for (int i = 0; i < 6; i++) begin
			go(CODES[i], 1'b0);
			if (CODES[i] != 7'h00) exp = CODES[i];
			`CHK(o_prog_num, exp)
			`CHK(n, 1)
		end
		$display("t_recall done");
	endtask : t_recall
	task automatic t_stroke();
		len = 8'h14;
		i_approach_req = 1'b1;
		do_reset();
		step(5);
		`CHK(o_approach_valve_out, 1'b0)
		go(7'h03, 1'b1);
		`CHK(n == N + 1 || n == N + 2, 1'b1)
		`CHK(o_approach_valve_out, 1'b1)
		go(7'h00, 1'b0);
		`CHK(n, 1)
		`CHK(vmid, 1'b1)
		`CHK(o_approach_valve_out, 1'b0)
		go(7'h00, 1'b1);
		`CHK(vmid, 1'b0)
		go(7'h00, 1'b1);
		`CHK(n == N + 1 || n == N + 2, 1'b1)
		`CHK(o_prog_num, 7'h03)
		i_approach_req = 1'b0;
		step(2);
		`CHK(o_approach_valve_out, 1'b0)
		$display("t_stroke done");
	endtask : t_stroke
	// A start edge seen while frozen acts on the first enabled edge; one in a weld is refused.
	task automatic t_freeze();
		clk_en = 1'b0;
		code = 7'h11;
		i_cycle_start = 1'b1;
		step(3);
		`CHK(o_cycle_busy, 1'b0)
		`CHK(o_prog_num, 7'h03)
		clk_en = 1'b1;
		step(1);
		`CHK(o_weld_go, 1'b1)
		`CHK(o_prog_num, 7'h11)
		i_cycle_start = 1'b0;
		step(1);
		code = 7'h22;
		i_cycle_start = 1'b1;
		step(2);
		`CHK(o_prog_num, 7'h11)
		`CHK(o_cycle_busy, 1'b1)
		while (o_cycle_busy !== 1'b0) step(1);
		i_cycle_start = 1'b0;
		step(1);
		`CHK(o_prog_num, 7'h11)
		$display("t_freeze done");
	endtask : t_freeze
	task automatic final_report();
		$display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : final_report
	initial begin
		do_reset();
		t_recall();
		t_stroke();
		t_freeze();
		final_report();
	end
endmodule : prds_ctrl_tb
bind prds_ctrl prds_ctrl_asserts #(.APPROACH_DELAY_CY(APPROACH_DELAY_CY)) u_chk (
	.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
	.i_approach_req(i_approach_req), .i_cycle_start(i_cycle_start),
	.i_cycle_end(i_cycle_end), .i_recall_in_weight1(i_recall_in_weight1),
	.i_recall_in_weight2(i_recall_in_weight2), .i_recall_in_weight4(i_recall_in_weight4),
	.i_recall_in_weight8(i_recall_in_weight8), .i_recall_in_weight16(i_recall_in_weight16),
	.i_recall_in_weight32(i_recall_in_weight32), .i_recall_in_weight64(i_recall_in_weight64),
	.o_prog_num(o_prog_num), .o_approach_valve_out(o_approach_valve_out),
	.o_weld_go(o_weld_go), .o_delay_busy(o_delay_busy), .o_cycle_busy(o_cycle_busy));
